/* core/tcrc_core.sv */
// Holds the conversion sequencer, result register, alert flags and data-line timeout.
// Assumes the serial shifter and host read logic run on I_REF_CLK; only I_SCL is asynchronous.
`timescale 1ns/1ps

module tcrc_core #(
   parameter int unsigned POWERUP_CYC = tcrc_pkg::POWERUP_CYC,
   parameter int unsigned CONV_CYC = tcrc_pkg::CONV_CYC,
   parameter int unsigned CYCLE_CYC = tcrc_pkg::CYCLE_CYC,
   parameter int unsigned BUS_TIMEOUT_CYC = tcrc_pkg::BUS_TIMEOUT_CYC
) (
   input wire logic I_REF_CLK,
   input wire logic I_RST_N,
   input wire logic I_START_SHUTDOWN,
   input wire logic I_CFG_WRITE,
   input wire tcrc_pkg::tcrc_cfg_t I_CFG_WDATA,
   input wire logic I_CFG_READ,
   input wire logic I_RESULT_READ,
   input wire logic I_READ_ACTIVE,
   input wire logic [15:0] I_ADC_SAMPLE,
   input wire logic I_SCL,
   input wire logic I_SDA_HOLD,
   output logic O_SDA_O,
   output logic O_SDA_OE,
   output logic [15:0] O_TEMPERATURE_RESULT,
   output tcrc_pkg::tcrc_status_t O_STATUS,
   output tcrc_pkg::tcrc_cfg_t O_CFG
);

   localparam tcrc_pkg::tcrc_cnt_t PU_LAST = tcrc_pkg::tcrc_cnt_t'(POWERUP_CYC - 1);
   localparam tcrc_pkg::tcrc_cnt_t CONV_LAST = tcrc_pkg::tcrc_cnt_t'(CONV_CYC - 1);
   localparam tcrc_pkg::tcrc_cnt_t CYCLE_LAST = tcrc_pkg::tcrc_cnt_t'(CYCLE_CYC - 1);
   localparam tcrc_pkg::tcrc_cnt_t TO_LAST = tcrc_pkg::tcrc_cnt_t'(BUS_TIMEOUT_CYC - 1);

   tcrc_pkg::tcrc_state_t state_r;
   tcrc_pkg::tcrc_state_t state_nxt;
   tcrc_pkg::tcrc_cfg_t cfg_r;
   tcrc_pkg::tcrc_cnt_t pu_cnt_r;
   tcrc_pkg::tcrc_cnt_t conv_cnt_r;
   tcrc_pkg::tcrc_cnt_t cyc_cnt_r;
   tcrc_pkg::tcrc_cnt_t to_cnt_r;
   logic start_active;
   logic abort;
   logic conv_tick;
   logic final_done;
   logic [3:0] acc_count;
   logic signed [15:0] acc_result;
   logic [15:0] result_r;
   logic [15:0] pend_val_r;
   logic pend_r;
   logic ever_done_r;
   logic data_ready_r;
   logic high_alert_r;
   logic low_alert_r;
   logic above_high;
   logic below_low;
   logic scl_s1_r;
   logic scl_s2_r;
   logic scl_d_r;
   logic scl_edge;
   logic timed_out_r;
   logic timeout_hit;
   logic sda_oe_r;

   // ---------------------------------------------------------------
   // Conversion sequencing
   // ---------------------------------------------------------------
   assign conv_tick = (state_r == tcrc_pkg::ST_ACTIVE) && (conv_cnt_r == CONV_LAST);
   assign final_done = conv_tick &&
                       ((acc_count + 4'h1) == tcrc_pkg::samples_per_result(cfg_r.averaging_select));
   assign abort = I_CFG_WRITE && (I_CFG_WDATA.conversion_regime_select == tcrc_pkg::REGIME_SHUT) &&
                  (state_r != tcrc_pkg::ST_POWERUP);

   always_comb begin
      state_nxt = state_r;
      start_active = 1'b0;
      case (state_r)
         tcrc_pkg::ST_POWERUP: begin
            if (pu_cnt_r == PU_LAST) begin
               if (tcrc_pkg::is_continuous(cfg_r.conversion_regime_select)) begin
                  state_nxt = tcrc_pkg::ST_ACTIVE;
                  start_active = 1'b1;
               end else begin
                  state_nxt = tcrc_pkg::ST_SHUTDOWN;
               end
            end
         end
         tcrc_pkg::ST_ACTIVE: begin
            if (final_done) begin
               if (cfg_r.conversion_regime_select == tcrc_pkg::REGIME_ONESHOT) begin
                  state_nxt = tcrc_pkg::ST_SHUTDOWN;
               end else begin
                  state_nxt = tcrc_pkg::ST_STANDBY;
               end
            end
         end
         tcrc_pkg::ST_STANDBY: begin
            if (cyc_cnt_r >= CYCLE_LAST) begin
               state_nxt = tcrc_pkg::ST_ACTIVE;
               start_active = 1'b1;
            end
         end
         tcrc_pkg::ST_SHUTDOWN: begin
            state_nxt = tcrc_pkg::ST_SHUTDOWN;
         end
         default: begin
            state_nxt = tcrc_pkg::ST_POWERUP;
         end
      endcase
      // Host writes of the regime field take effect at once after power-up, except a continuous write in a single shot's last cycle, which ends in shutdown.
      if (state_r != tcrc_pkg::ST_POWERUP && I_CFG_WRITE) begin
         if (abort) begin
            state_nxt = tcrc_pkg::ST_SHUTDOWN;
            start_active = 1'b0;
         end else if (I_CFG_WDATA.conversion_regime_select == tcrc_pkg::REGIME_ONESHOT) begin
            state_nxt = tcrc_pkg::ST_ACTIVE;
            start_active = 1'b1;
         end else if (state_r == tcrc_pkg::ST_SHUTDOWN) begin
            state_nxt = tcrc_pkg::ST_ACTIVE;
            start_active = 1'b1;
         end
      end
   end

   always_ff @(posedge I_REF_CLK) begin
      if (!I_RST_N) begin
         state_r <= tcrc_pkg::ST_POWERUP;
      end else begin
         state_r <= state_nxt;
      end
   end

   always_ff @(posedge I_REF_CLK) begin
      if (!I_RST_N) begin
         pu_cnt_r <= '0;
      end else if (state_r == tcrc_pkg::ST_POWERUP && pu_cnt_r != PU_LAST) begin
         pu_cnt_r <= pu_cnt_r + 26'h1;
      end
   end

   always_ff @(posedge I_REF_CLK) begin
      if (!I_RST_N || start_active || conv_tick || state_r != tcrc_pkg::ST_ACTIVE) begin
         conv_cnt_r <= '0;
      end else begin
         conv_cnt_r <= conv_cnt_r + 26'h1;
      end
   end

   // The cycle counter runs from the start of the active period through standby.
   always_ff @(posedge I_REF_CLK) begin
      if (!I_RST_N || start_active) begin
         cyc_cnt_r <= '0;
      end else if (cyc_cnt_r != CYCLE_LAST) begin
         cyc_cnt_r <= cyc_cnt_r + 26'h1;
      end
   end

   // ---------------------------------------------------------------
   // Configuration
   // ---------------------------------------------------------------
   always_ff @(posedge I_REF_CLK) begin
      if (!I_RST_N) begin
         cfg_r.conversion_regime_select <= I_START_SHUTDOWN ? tcrc_pkg::REGIME_SHUT
                                                            : tcrc_pkg::REGIME_CONT;
         cfg_r.averaging_select <= tcrc_pkg::AVG_RESET;
         cfg_r.therm_mode <= tcrc_pkg::THERM_RESET;
         cfg_r.high_limit <= tcrc_pkg::HIGH_LIMIT_RESET;
         cfg_r.low_limit <= tcrc_pkg::LOW_LIMIT_RESET;
      end else if (I_CFG_WRITE) begin
         cfg_r <= I_CFG_WDATA;
      end else if (final_done && cfg_r.conversion_regime_select == tcrc_pkg::REGIME_ONESHOT) begin
         cfg_r.conversion_regime_select <= tcrc_pkg::REGIME_SHUT;
      end
   end

   // ---------------------------------------------------------------
   // Averaging and result
   // ---------------------------------------------------------------
   tcrc_avg_acc u_acc (
      .i_clk(I_REF_CLK),
      .i_rst_n(I_RST_N),
      .i_clear(start_active || final_done || abort),
      .i_add(conv_tick && !final_done),
      .i_avg8(cfg_r.averaging_select == tcrc_pkg::AVG_SEL_EIGHT),
      .i_sample(I_ADC_SAMPLE),
      .o_count(acc_count),
      .o_result(acc_result)
   );

   // A result finishing during a host read waits whole and lands when the read ends.
   always_ff @(posedge I_REF_CLK) begin
      if (!I_RST_N) begin
         result_r <= tcrc_pkg::RESULT_RESET;
         pend_val_r <= tcrc_pkg::RESULT_RESET;
         pend_r <= 1'b0;
      end else if (final_done) begin
         if (I_READ_ACTIVE) begin
            pend_val_r <= acc_result;
            pend_r <= 1'b1;
         end else begin
            result_r <= acc_result;
            pend_r <= 1'b0;
         end
      end else if (pend_r && !I_READ_ACTIVE) begin
         result_r <= pend_val_r;
         pend_r <= 1'b0;
      end
   end

   always_ff @(posedge I_REF_CLK) begin
      if (!I_RST_N) begin
         ever_done_r <= 1'b0;
      end else if (final_done) begin
         ever_done_r <= 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // Data ready and alert flags
   // ---------------------------------------------------------------
   assign above_high = acc_result > $signed(cfg_r.high_limit);
   assign below_low = acc_result < $signed(cfg_r.low_limit);

   always_ff @(posedge I_REF_CLK) begin
      if (!I_RST_N) begin
         data_ready_r <= 1'b0;
      end else if (final_done) begin
         data_ready_r <= 1'b1;
      end else if (I_RESULT_READ || I_CFG_READ) begin
         data_ready_r <= 1'b0;
      end
   end

   // Alert mode: sticky until a configuration read. Therm mode: high with hysteresis.
   always_ff @(posedge I_REF_CLK) begin
      if (!I_RST_N) begin
         high_alert_r <= 1'b0;
         low_alert_r <= 1'b0;
      end else if (cfg_r.therm_mode) begin
         low_alert_r <= 1'b0;
         if (final_done && above_high) begin
            high_alert_r <= 1'b1;
         end else if (final_done && below_low) begin
            high_alert_r <= 1'b0;
         end
      end else begin
         if (final_done && above_high) begin
            high_alert_r <= 1'b1;
         end else if (I_CFG_READ) begin
            high_alert_r <= 1'b0;
         end
         if (final_done && below_low) begin
            low_alert_r <= 1'b1;
         end else if (I_CFG_READ) begin
            low_alert_r <= 1'b0;
         end
      end
   end

   // ---------------------------------------------------------------
   // Serial clock stall timeout
   // ---------------------------------------------------------------
   always_ff @(posedge I_REF_CLK) begin
      if (!I_RST_N) begin
         scl_s1_r <= 1'b1;
         scl_s2_r <= 1'b1;
         scl_d_r <= 1'b1;
      end else begin
         scl_s1_r <= I_SCL;
         scl_s2_r <= scl_s1_r;
         scl_d_r <= scl_s2_r;
      end
   end

   assign scl_edge = scl_s2_r ^ scl_d_r;
   assign timeout_hit = I_SDA_HOLD && !scl_edge && (to_cnt_r == TO_LAST);

   always_ff @(posedge I_REF_CLK) begin
      if (!I_RST_N || !I_SDA_HOLD || scl_edge) begin
         to_cnt_r <= '0;
         timed_out_r <= 1'b0;
      end else if (timeout_hit) begin
         timed_out_r <= 1'b1;
      end else if (!timed_out_r) begin
         to_cnt_r <= to_cnt_r + 26'h1;
      end
   end

   always_ff @(posedge I_REF_CLK) begin
      if (!I_RST_N) begin
         sda_oe_r <= 1'b0;
      end else begin
         sda_oe_r <= I_SDA_HOLD && !timed_out_r && !timeout_hit;
      end
   end

   assign O_SDA_O = 1'b0;
   assign O_SDA_OE = sda_oe_r;
   assign O_TEMPERATURE_RESULT = result_r;
   assign O_CFG = cfg_r;
   assign O_STATUS.busy = (state_r == tcrc_pkg::ST_ACTIVE);
   assign O_STATUS.data_ready = data_ready_r;
   assign O_STATUS.high_alert = high_alert_r;
   assign O_STATUS.low_alert = low_alert_r;

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge I_REF_CLK); endclocking
   default disable iff (!I_RST_N);

   sequence s_final_cont;
      final_done && tcrc_pkg::is_continuous(cfg_r.conversion_regime_select) && !I_CFG_WRITE;
   endsequence

   sequence s_final_oneshot;
      final_done && cfg_r.conversion_regime_select == tcrc_pkg::REGIME_ONESHOT && !I_CFG_WRITE;
   endsequence

   a_powerup_wait: assert property (pu_cnt_r != PU_LAST |-> state_r == tcrc_pkg::ST_POWERUP)
      else $error("Left power-up before the interval ended.");
   a_result_initial: assert property (!ever_done_r |-> result_r == tcrc_pkg::RESULT_RESET)
      else $error("Result changed before the first conversion.");
   a_boot_shutdown: assert property ((state_r == tcrc_pkg::ST_POWERUP && pu_cnt_r == PU_LAST &&
      cfg_r.conversion_regime_select == tcrc_pkg::REGIME_SHUT) |=> state_r == tcrc_pkg::ST_SHUTDOWN)
      else $error("Shutdown start-up not honoured.");
   a_avg_eight: assert property ((final_done && cfg_r.averaging_select == tcrc_pkg::AVG_SEL_EIGHT)
      |-> acc_count == 4'h7)
      else $error("Averaged result not after eight conversions.");
   a_conv_time: assert property ((state_r == tcrc_pkg::ST_ACTIVE && conv_cnt_r != CONV_LAST)
      |-> !final_done)
      else $error("Conversion ended before its active time.");
   a_default_avg: assert property ($rose(I_RST_N) |-> cfg_r.averaging_select == tcrc_pkg::AVG_RESET)
      else $error("Averaging default wrong after reset.");
   a_result_write: assert property ((final_done && !I_READ_ACTIVE)
      |=> result_r == $past(acc_result))
      else $error("Result not written at conversion end.");
   a_therm_low: assert property (cfg_r.therm_mode ##1 cfg_r.therm_mode |-> !low_alert_r)
      else $error("Low flag set in therm mode.");
   a_abort_now: assert property (abort |=> state_r == tcrc_pkg::ST_SHUTDOWN && acc_count == 4'h0)
      else $error("Shutdown did not abort at once.");
   a_cont_standby: assert property (s_final_cont |=> state_r == tcrc_pkg::ST_STANDBY)
      else $error("Continuous conversion not followed by standby.");
   a_oneshot_back: assert property (s_final_oneshot |=> state_r == tcrc_pkg::ST_SHUTDOWN &&
      cfg_r.conversion_regime_select == tcrc_pkg::REGIME_SHUT)
      else $error("Single shot did not return to shutdown.");
   a_bus_release: assert property ((timeout_hit ##1 I_SDA_HOLD) |-> !O_SDA_OE)
      else $error("Data line held after the clock-stall timeout.");
   a_read_atomic: assert property ((I_READ_ACTIVE ##1 I_READ_ACTIVE) |-> $stable(result_r))
      else $error("Result changed during a host read.");

endmodule

/* core/tcrc_pkg.sv */
// Holds the shared constants, types and helpers of the temperature conversion and result core.
// Assumes a single 40 MHz reference clock and a synchronous active-low reset in every user.

package tcrc_pkg;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int unsigned CLK_KHZ = 40000;
   localparam int unsigned POWERUP_TIME_US = 1500;
   localparam int unsigned CONV_TIME_US = 15500;
   localparam int unsigned CYCLE_TIME_MS = 1000;
   localparam int unsigned BUS_TIMEOUT_MIN_MS = 20;
   localparam int unsigned BUS_TIMEOUT_MAX_MS = 40;
   localparam int unsigned POWERUP_CYC = (POWERUP_TIME_US * CLK_KHZ + 999) / 1000;
   localparam int unsigned CONV_CYC = (CONV_TIME_US * CLK_KHZ + 999) / 1000;
   localparam int unsigned CYCLE_CYC = CYCLE_TIME_MS * CLK_KHZ;
   localparam int unsigned BUS_TIMEOUT_CYC = BUS_TIMEOUT_MIN_MS * CLK_KHZ;

   typedef logic [25:0] tcrc_cnt_t;

   // ---------------------------------------------------------------
   // Data format and reset values
   // ---------------------------------------------------------------
   localparam int unsigned AVG_SHIFT = 3;
   localparam logic [3:0] AVG_DEPTH = 4'h8;
   localparam logic [3:0] SINGLE_DEPTH = 4'h1;
   localparam logic [1:0] AVG_SEL_NONE = 2'h0;
   localparam logic [1:0] AVG_SEL_EIGHT = 2'h1;
   localparam logic [15:0] RESULT_RESET = 16'h8000;
   localparam logic [1:0] AVG_RESET = AVG_SEL_EIGHT;
   localparam logic [15:0] HIGH_LIMIT_RESET = 16'h6000;
   localparam logic [15:0] LOW_LIMIT_RESET = 16'h8000;
   localparam logic THERM_RESET = 1'b0;

   typedef enum logic [1:0] {
      REGIME_CONT = 2'h0,
      REGIME_SHUT = 2'h1,
      REGIME_CONT_ALT = 2'h2,
      REGIME_ONESHOT = 2'h3
   } tcrc_regime_t;

   typedef enum logic [1:0] {
      ST_POWERUP = 2'h0,
      ST_ACTIVE = 2'h1,
      ST_STANDBY = 2'h3,
      ST_SHUTDOWN = 2'h2
   } tcrc_state_t;

   typedef struct packed {
      tcrc_regime_t conversion_regime_select;
      logic [1:0] averaging_select;
      logic therm_mode;
      logic [15:0] high_limit;
      logic [15:0] low_limit;
   } tcrc_cfg_t;

   typedef struct packed {
      logic busy;
      logic data_ready;
      logic high_alert;
      logic low_alert;
   } tcrc_status_t;

   // Number of single conversions that make up one stored result.
   function automatic logic [3:0] samples_per_result(input logic [1:0] sel);
      return (sel == AVG_SEL_EIGHT) ? AVG_DEPTH : SINGLE_DEPTH;
   endfunction

   function automatic logic is_continuous(input tcrc_regime_t r);
      return (r == REGIME_CONT) || (r == REGIME_CONT_ALT);
   endfunction

endpackage

/* core/tcrc_avg_acc.sv */
// Holds the sample accumulator that forms single or eight-sample averaged results.
// Assumes samples arrive from logic on the same clock, one per conversion end.
`timescale 1ns/1ps

module tcrc_avg_acc (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_clear,
   input wire logic i_add,
   input wire logic i_avg8,
   input wire logic signed [15:0] i_sample,
   output logic [3:0] o_count,
   output logic signed [15:0] o_result
);

   logic signed [18:0] sum_r;
   logic signed [18:0] sum_plus;
   logic [3:0] count_r;

   assign sum_plus = sum_r + 19'(i_sample);
   // Arithmetic shift keeps the two's complement sign of the average.
   assign o_result = i_avg8 ? 16'(sum_plus >>> tcrc_pkg::AVG_SHIFT) : i_sample;
   assign o_count = count_r;

   // ---------------------------------------------------------------
   // Accumulation
   // ---------------------------------------------------------------
   always_ff @(posedge i_clk) begin
      if (!i_rst_n || i_clear) begin
         sum_r <= '0;
         count_r <= 4'h0;
      end else if (i_add) begin
         sum_r <= sum_plus;
         count_r <= count_r + 4'h1;
      end
   end

endmodule

/* verif/tcrc_host_model.sv */
// Holds a behavioural serial host that makes the link clock for the core.
// Assumes the bench raises i_frame for a frame; the clock idles high outside it.
`timescale 1ns/1ps

module tcrc_host_model (
   input wire logic i_frame,
   output logic o_scl
);
   // The clock toggles every 100 ns inside a frame and rests at the pull-up level outside it.
   initial begin
      o_scl = 1'b1;
      forever begin
         #100;
         o_scl = i_frame ? ~o_scl : 1'b1;
      end
   end
endmodule

/* verif/test_temp_conversion_result_core.sv */
// Holds the self-checking bench of the temperature conversion and result core.
// Assumes short count parameters and a host model that makes the serial clock.
`timescale 1ns/1ps

module test_temp_conversion_result_core;
   typedef struct {
      logic [1:0] rg;
      logic [1:0] av;
      logic [15:0] smp;
      logic [15:0] hi;
      logic [15:0] lo;
      int cyc;
      logic [1:0] fl;
   } tcrc_row_t;
   logic clk, rst_n, strap, cw, cr, rr, ra, hold, frame, scl, sda_o, sda_oe, tm;
   logic [15:0] smp, res;
   tcrc_pkg::tcrc_cfg_t wd, cfg;
   tcrc_pkg::tcrc_status_t st;
   int fail_count = 0;
   int n_checks = 0;
   int c;
   tcrc_row_t rows [4] = '{
      '{2'h3, 2'h0, 16'h0c80, 16'h6000, 16'h8000, 10, 2'h0},
      '{2'h3, 2'h1, 16'hf380, 16'h6000, 16'h8000, 80, 2'h0},
      '{2'h3, 2'h2, 16'h7fff, 16'h3200, 16'h8000, 10, 2'h2},
      '{2'h3, 2'h3, 16'h8000, 16'h6000, 16'hfff0, 10, 2'h1}};

   tcrc_core #(.POWERUP_CYC(20), .CONV_CYC(10), .CYCLE_CYC(200), .BUS_TIMEOUT_CYC(50)) dut (
      .I_REF_CLK(clk), .I_RST_N(rst_n), .I_START_SHUTDOWN(strap), .I_CFG_WRITE(cw),
      .I_CFG_WDATA(wd), .I_CFG_READ(cr), .I_RESULT_READ(rr), .I_READ_ACTIVE(ra),
      .I_ADC_SAMPLE(smp), .I_SCL(scl), .I_SDA_HOLD(hold), .O_SDA_O(sda_o),
      .O_SDA_OE(sda_oe), .O_TEMPERATURE_RESULT(res), .O_STATUS(st), .O_CFG(cfg));

   tcrc_host_model host (.i_frame(frame), .o_scl(scl));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   task automatic report_and_stop();
      $display("checks=%0d mismatches=%0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   task automatic chk(input logic [36:0] got, input logic [36:0] exp);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic wr(input logic [1:0] rg, input logic [1:0] av, input logic [15:0] hi, input logic [15:0] lo);
      @(posedge clk);
      cw <= 1'b1;
      wd <= {rg, av, tm, hi, lo};
      @(posedge clk);
      cw <= 1'b0;
   endtask

   task automatic rd_cfg();
      @(posedge clk);
      cr <= 1'b1;
      @(posedge clk);
      cr <= 1'b0;
   endtask

   // Counts falling edges until busy reaches the given level.
   task automatic wait_st(input logic lvl, output int n);
      n = 0;
      do begin
         @(negedge clk);
         n++;
         if (n > 2000) begin
            fail_count++;
            report_and_stop();
         end
      end while (st.busy !== lvl);
   endtask

   // Counts falling edges until the data-line enable reaches the given level.
   task automatic wait_oe(input logic lvl, output int n);
      n = 0;
      do begin
         @(negedge clk);
         n++;
         if (n > 500) begin
            fail_count++;
            report_and_stop();
         end
      end while (sda_oe !== lvl);
   endtask

   // ---------------------------------------------------------------
   // Sequence
   // ---------------------------------------------------------------
   initial begin
      rst_n = 1'b0;
      strap = 1'b0;
      cw = 1'b0;
      cr = 1'b0;
      rr = 1'b0;
      ra = 1'b0;
      hold = 1'b0;
      frame = 1'b0;
      tm = 1'b0;
      smp = 16'h0080;
      wd = '0;
      repeat (8) @(posedge clk);
      @(negedge clk);
      chk(res, tcrc_pkg::RESULT_RESET);
      chk(cfg, {2'h0, tcrc_pkg::AVG_RESET, tcrc_pkg::THERM_RESET, 16'h6000, 16'h8000});
      chk(st, 4'h0);
      @(posedge clk);
      rst_n <= 1'b1;
      wait_st(1'b1, c);
      chk(c >= 20 && c <= 23, 1'b1);
      chk(res, 16'h8000);
      wait_st(1'b0, c);
      chk(c, 80);
      @(negedge clk);
      chk(res, 16'h0080);
      chk(st.data_ready, 1'b1);
      wait_st(1'b1, c);
      chk(c, 119);
      $display("power-up and default cycle done");

      foreach (rows[i]) begin
         wr(2'h1, 2'h0, rows[i].hi, rows[i].lo);
         smp <= rows[i].smp;
         rd_cfg();
         wr(rows[i].rg, rows[i].av, rows[i].hi, rows[i].lo);
         wait_st(1'b1, c);
         wait_st(1'b0, c);
         chk(c, rows[i].cyc);
         @(negedge clk);
         chk(res, rows[i].smp);
         chk(st[2:0], {1'b1, rows[i].fl});
         chk(cfg.conversion_regime_select, tcrc_pkg::REGIME_SHUT);
         $display("one-shot row %0d done", i);
      end

      wr(2'h2, 2'h0, 16'h6000, 16'h8000);
      smp <= 16'h0010;
      wait_st(1'b1, c);
      cyc(3);
      wr(2'h1, 2'h0, 16'h6000, 16'h8000);
      wait_st(1'b0, c);
      chk(c, 1);
      chk(res, 16'h8000);
      wr(2'h2, 2'h0, 16'h6000, 16'h8000);
      wait_st(1'b1, c);
      wait_st(1'b0, c);
      chk(c, 10);
      @(negedge clk);
      chk(res, 16'h0010);
      $display("abort and alternate continuous done");

      wr(2'h1, 2'h0, 16'h6000, 16'h8000);
      smp <= 16'h0001;
      ra <= 1'b1;
      wr(2'h3, 2'h0, 16'h6000, 16'h8000);
      wait_st(1'b1, c);
      wait_st(1'b0, c);
      cyc(3);
      @(negedge clk);
      chk(res, 16'h0010);
      @(posedge clk);
      ra <= 1'b0;
      cyc(2);
      @(negedge clk);
      chk(res, 16'h0001);
      @(posedge clk);
      rr <= 1'b1;
      @(posedge clk);
      rr <= 1'b0;
      @(negedge clk);
      chk(st.data_ready, 1'b0);
      $display("frozen result done");

      // Therm mode: a configuration read leaves the high flag, a low result clears it.
      tm = 1'b1;
      wr(2'h3, 2'h0, 16'h3200, 16'h0c80);
      smp <= 16'h7fff;
      wait_st(1'b1, c);
      wait_st(1'b0, c);
      rd_cfg();
      @(negedge clk);
      chk(st[1:0], 2'h2);
      wr(2'h3, 2'h0, 16'h3200, 16'h0c80);
      smp <= 16'h0080;
      wait_st(1'b1, c);
      wait_st(1'b0, c);
      @(negedge clk);
      chk(st[1:0], 2'h0);
      tm = 1'b0;
      $display("therm mode done");

      @(posedge clk);
      hold <= 1'b1;
      wait_oe(1'b1, c);
      wait_oe(1'b0, c);
      chk(c >= 48 && c <= 53, 1'b1);
      chk(sda_o, 1'b0);
      @(posedge clk);
      hold <= 1'b0;
      frame <= 1'b1;
      cyc(2);
      hold <= 1'b1;
      wait_oe(1'b1, c);
      cyc(100);
      @(negedge clk);
      chk(sda_oe, 1'b1);
      @(posedge clk);
      frame <= 1'b0;
      wait_oe(1'b0, c);
      chk(c >= 48 && c <= 60, 1'b1);
      @(posedge clk);
      hold <= 1'b0;
      $display("bus timeout done");

      strap <= 1'b1;
      rst_n <= 1'b0;
      cyc(8);
      @(negedge clk);
      chk(cfg.conversion_regime_select, tcrc_pkg::REGIME_SHUT);
      chk(res, 16'h8000);
      @(posedge clk);
      rst_n <= 1'b1;
      cyc(60);
      @(negedge clk);
      chk(st.busy, 1'b0);
      $display("shutdown start-up done");
      report_and_stop();
   end
endmodule
